// *** logic/esr_bank.sv ***
// register bank of the humidity and temperature sensor
// assumes the i2c engine delivers one byte event per cycle on the same clock
// and the conversion engine pulses done with fresh 14-bit results
//
// Summary of operation
// - temperature bytes at 0x00/0x01, reset zero
// - temperature word 16-bit, two low bits zero
// - 14-bit result, resolution from measurement config
// - humidity bytes at 0x02/0x03, reset zero
// - humidity word 16-bit, two low bits zero
// - conversion end sets done flag bit 7
// - status or result read clears done flag
// - threshold flags bits 6..3, reserved read zero
// - status read clears threshold flags
// - config 0x0E picks latched or tracking flags
// - alert pin follows flags, same mode
// - temperature peak byte at 0x05
// - humidity peak byte at 0x06
// - soft reset and alert config at 0x0E
// - 0x04 merges done and threshold flags
// - latch mode: flag holds until status read
// - track mode: flag follows present value
// - pointer increments after every data byte
// - nack id writes and unused pointer
module esr_bank
    import esr_pkg::*;
#(
    parameter logic [7:0] MAKER_LO = 8'hA5, // arbitrary identity value
    parameter logic [7:0] MAKER_HI = 8'h5A, // arbitrary identity value
    parameter logic [7:0] PART_LO  = 8'h3C, // arbitrary identity value
    parameter logic [7:0] PART_HI  = 8'hC3  // arbitrary identity value
) (
    input  wire logic      clk,
    input  wire logic      reset_n,
    input  wire esr_req_s  bus_req,
    output esr_rsp_s       bus_rsp,
    input  wire esr_conv_s conv,
    output logic           alert_pin
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]  ptr_ff;
    logic [15:0] temp_ff;
    logic [15:0] hum_ff;
    logic        done_ff;
    logic [3:0]  thr_ff;
    logic [7:0]  temp_peak_ff;
    logic [7:0]  hum_peak_ff;
    logic [7:0]  enable_ff;
    logic [7:0]  temp_trim_ff;
    logic [7:0]  hum_trim_ff;
    logic [7:0]  tlim_a_ff;
    logic [7:0]  tlim_b_ff;
    logic [7:0]  hlim_a_ff;
    logic [7:0]  hlim_b_ff;
    logic [7:0]  cfg_ff;
    logic [7:0]  meas_ff;
    logic        soft_ff;
    esr_rsp_s    rsp_ff;
    logic        alert_ff;

    logic        clr;
    logic        ptr_byte;
    logic        wr_byte;
    logic        rd_byte;
    logic        ptr_mapped;
    logic        ptr_is_id;
    logic        rd_status;
    logic        rd_result;
    logic [7:0]  rd_mux;
    logic [15:0] nxt_temp;
    logic [15:0] nxt_hum;
    logic [3:0]  cond;
    logic [7:0]  status;
    logic [7:0]  temp_peak_base;
    logic [7:0]  hum_peak_base;
    logic        alert_active;
    logic        nxt_alert;

    ////////////////////////////////////////////////////////////////////////////
    // conversion word shaping
    function automatic logic [15:0] esr_adjust(
        input logic [13:0] raw,
        input logic [7:0]  trim,
        input logic [1:0]  res
    );
        logic signed [17:0] sum;
        logic [15:0]        word;
        logic [15:0]        keep;
        sum = $signed({2'b00, raw, 2'b00}) + $signed({{4{trim[7]}}, trim, 6'h00});
        // saturate so an offset never wraps a cold reading to hot
        if (sum < 0) begin
            word = 16'h0000;
        end else if (sum > $signed(18'h0FFFF)) begin
            word = 16'hFFFF;
        end else begin
            word = sum[15:0];
        end
        case (res)
            ESR_RES_11: keep = ESR_KEEP_11;
            ESR_RES_9:  keep = ESR_KEEP_9;
            default:    keep = ESR_KEEP_14;
        endcase
        return word & keep & ESR_KEEP_14;
    endfunction

    assign nxt_temp = esr_adjust(conv.temp, temp_trim_ff,
                                 meas_ff[ESR_MEAS_TRES_LSB +: 2]);
    assign nxt_hum  = esr_adjust(conv.hum, hum_trim_ff,
                                 meas_ff[ESR_MEAS_HRES_LSB +: 2]);

    // limit a is the upper bound, limit b the lower; enable bits 6..3 arm the flags
    assign cond = {nxt_temp[15:8] > tlim_a_ff, nxt_temp[15:8] < tlim_b_ff,
                   nxt_hum[15:8] > hlim_a_ff,  nxt_hum[15:8] < hlim_b_ff}
                  & enable_ff[ESR_FLAG_THR_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////////
    // byte decode
    assign clr        = !reset_n || soft_ff;
    assign ptr_byte   = bus_req.valid && bus_req.kind == ESR_KIND_PTR;
    assign wr_byte    = bus_req.valid && bus_req.kind == ESR_KIND_WRITE;
    assign rd_byte    = bus_req.valid && bus_req.kind == ESR_KIND_READ;
    assign ptr_is_id  = ptr_ff >= ESR_OFF_MAKER_LO;
    assign ptr_mapped = bus_req.data <= ESR_OFF_MEAS || bus_req.data >= ESR_OFF_MAKER_LO;
    assign rd_status  = rd_byte && ptr_ff == ESR_OFF_FLAGS;
    assign rd_result  = rd_byte && ptr_ff <= ESR_OFF_HUM_HI;
    assign status     = {done_ff, thr_ff, 3'b000};

    always_comb begin
        case (ptr_ff)
            ESR_OFF_TEMP_LO:   rd_mux = temp_ff[7:0];
            ESR_OFF_TEMP_HI:   rd_mux = temp_ff[15:8];
            ESR_OFF_HUM_LO:    rd_mux = hum_ff[7:0];
            ESR_OFF_HUM_HI:    rd_mux = hum_ff[15:8];
            ESR_OFF_FLAGS:     rd_mux = status;
            ESR_OFF_TEMP_PEAK: rd_mux = temp_peak_ff;
            ESR_OFF_HUM_PEAK:  rd_mux = hum_peak_ff;
            ESR_OFF_ENABLE:    rd_mux = enable_ff;
            ESR_OFF_TEMP_TRIM: rd_mux = temp_trim_ff;
            ESR_OFF_HUM_TRIM:  rd_mux = hum_trim_ff;
            ESR_OFF_TLIM_A:    rd_mux = tlim_a_ff;
            ESR_OFF_TLIM_B:    rd_mux = tlim_b_ff;
            ESR_OFF_HLIM_A:    rd_mux = hlim_a_ff;
            ESR_OFF_HLIM_B:    rd_mux = hlim_b_ff;
            ESR_OFF_CFG:       rd_mux = cfg_ff;
            ESR_OFF_MEAS:      rd_mux = meas_ff;
            ESR_OFF_MAKER_LO:  rd_mux = MAKER_LO;
            ESR_OFF_MAKER_HI:  rd_mux = MAKER_HI;
            ESR_OFF_PART_LO:   rd_mux = PART_LO;
            ESR_OFF_PART_HI:   rd_mux = PART_HI;
            default:           rd_mux = ESR_RST_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer and byte answers
    always_ff @(posedge clk) begin
        if (clr) begin
            ptr_ff <= ESR_RST_ZERO;
        end else if (ptr_byte) begin
            ptr_ff <= bus_req.data;
        end else if (wr_byte || rd_byte) begin
            ptr_ff <= ptr_ff + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.valid <= bus_req.valid;
            if (ptr_byte) begin
                rsp_ff.ack <= ptr_mapped;
            end else if (wr_byte) begin
                rsp_ff.ack <= !ptr_is_id;
            end else begin
                rsp_ff.ack <= 1'b1;
            end
            if (rd_byte) begin
                rsp_ff.data <= rd_mux;
            end
        end
    end

    assign bus_rsp = rsp_ff;

    ////////////////////////////////////////////////////////////////////////////
    // soft reset: one-cycle pulse, the bit itself reads back zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            soft_ff <= 1'b0;
        end else begin
            soft_ff <= wr_byte && ptr_ff == ESR_OFF_CFG && bus_req.data[ESR_CFG_SOFT_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            cfg_ff <= ESR_RST_ZERO;
        end else if (wr_byte && ptr_ff == ESR_OFF_CFG) begin
            cfg_ff <= bus_req.data & ~(8'h01 << ESR_CFG_SOFT_BIT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // plain read-write registers
    always_ff @(posedge clk) begin
        if (clr) begin
            enable_ff    <= ESR_RST_ZERO;
            temp_trim_ff <= ESR_RST_ZERO;
            hum_trim_ff  <= ESR_RST_ZERO;
            tlim_a_ff    <= ESR_RST_LIMIT_A;
            tlim_b_ff    <= ESR_RST_ZERO;
            hlim_a_ff    <= ESR_RST_LIMIT_A;
            hlim_b_ff    <= ESR_RST_ZERO;
            meas_ff      <= ESR_RST_ZERO;
        end else if (wr_byte) begin
            case (ptr_ff)
                ESR_OFF_ENABLE:    enable_ff    <= bus_req.data & 8'hF8;
                ESR_OFF_TEMP_TRIM: temp_trim_ff <= bus_req.data;
                ESR_OFF_HUM_TRIM:  hum_trim_ff  <= bus_req.data;
                ESR_OFF_TLIM_A:    tlim_a_ff    <= bus_req.data;
                ESR_OFF_TLIM_B:    tlim_b_ff    <= bus_req.data;
                ESR_OFF_HLIM_A:    hlim_a_ff    <= bus_req.data;
                ESR_OFF_HLIM_B:    hlim_b_ff    <= bus_req.data;
                ESR_OFF_MEAS:      meas_ff      <= bus_req.data;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // results and peak detectors
    always_ff @(posedge clk) begin
        if (clr) begin
            temp_ff <= ESR_RST_RESULT;
            hum_ff  <= ESR_RST_RESULT;
        end else if (conv.done) begin
            temp_ff <= nxt_temp;
            hum_ff  <= nxt_hum;
        end
    end

    // a write of zero erases the peak; a same-cycle conversion still counts
    assign temp_peak_base = (wr_byte && ptr_ff == ESR_OFF_TEMP_PEAK) ? bus_req.data
                                                                     : temp_peak_ff;
    assign hum_peak_base  = (wr_byte && ptr_ff == ESR_OFF_HUM_PEAK) ? bus_req.data
                                                                    : hum_peak_ff;

    always_ff @(posedge clk) begin
        if (clr) begin
            temp_peak_ff <= ESR_RST_ZERO;
            hum_peak_ff  <= ESR_RST_ZERO;
        end else begin
            if (conv.done && nxt_temp[15:8] > temp_peak_base) begin
                temp_peak_ff <= nxt_temp[15:8];
            end else begin
                temp_peak_ff <= temp_peak_base;
            end
            if (conv.done && nxt_hum[15:8] > hum_peak_base) begin
                hum_peak_ff <= nxt_hum[15:8];
            end else begin
                hum_peak_ff <= hum_peak_base;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags: a new conversion always beats a clearing read
    always_ff @(posedge clk) begin
        if (clr) begin
            done_ff <= 1'b0;
        end else if (conv.done) begin
            done_ff <= 1'b1;
        end else if (rd_status || rd_result) begin
            done_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            thr_ff <= 4'h0;
        end else if (cfg_ff[ESR_CFG_LATCH_BIT]) begin
            thr_ff <= (rd_status ? 4'h0 : thr_ff) | (conv.done ? cond : 4'h0);
        end else if (conv.done) begin
            thr_ff <= cond;
        end else if (rd_status) begin
            thr_ff <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alert pin: registered so it never glitches between flag updates
    assign alert_active = cfg_ff[ESR_CFG_EN_BIT]
                          && |({done_ff, thr_ff} & enable_ff[7:3]);
    assign nxt_alert    = cfg_ff[ESR_CFG_POL_BIT] ? alert_active : !alert_active;

    always_ff @(posedge clk) begin
        if (clr) begin
            alert_ff <= ESR_RST_ALERT;
        end else begin
            alert_ff <= nxt_alert;
        end
    end

    assign alert_pin = alert_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence seq_clean;
        !soft_ff && !conv.done;
    endsequence

    sequence seq_status_read;
        rd_status && !soft_ff;
    endsequence

    done_set_a: assert property (
        conv.done && !soft_ff |=> done_ff && status[7])
        else $error("done flag not set after conversion");

    done_clear_a: assert property (
        (rd_status || rd_result) && !conv.done && !soft_ff |=> !done_ff)
        else $error("done flag survived a clearing read");

    low_bits_a: assert property (
        temp_ff[1:0] == 2'b00 && hum_ff[1:0] == 2'b00 && status[2:0] == 3'b000)
        else $error("forced zero bits are set");

    latch_hold_a: assert property (
        cfg_ff[ESR_CFG_LATCH_BIT] && !rd_status && !soft_ff
        |=> (thr_ff & $past(thr_ff)) == $past(thr_ff))
        else $error("latched flag dropped without status read");

    track_flag_a: assert property (
        !cfg_ff[ESR_CFG_LATCH_BIT] && conv.done && !soft_ff |=> thr_ff == $past(cond))
        else $error("tracking flag differs from present condition");

    thr_clear_a: assert property (
        seq_status_read ##0 seq_clean |=> thr_ff == 4'h0)
        else $error("threshold flags not cleared by status read");

    ptr_step_a: assert property (
        (wr_byte || rd_byte) && !soft_ff |=> ptr_ff == $past(ptr_ff) + 8'h01)
        else $error("pointer did not advance");

    id_nack_a: assert property (
        wr_byte && ptr_is_id |=> bus_rsp.valid && !bus_rsp.ack)
        else $error("identity write was acknowledged");

    unused_nack_a: assert property (
        ptr_byte && !ptr_mapped && !soft_ff
        |=> bus_rsp.valid && !bus_rsp.ack && ptr_ff == $past(bus_req.data))
        else $error("unused pointer was acknowledged");

    read_value_a: assert property (
        rd_byte |=> bus_rsp.valid && bus_rsp.data == $past(rd_mux))
        else $error("read data not the value before the read");

    peak_keep_a: assert property (
        conv.done && !soft_ff && !(wr_byte && ptr_ff == ESR_OFF_TEMP_PEAK)
        |=> temp_peak_ff >= $past(temp_peak_ff) && temp_peak_ff >= $past(nxt_temp[15:8]))
        else $error("temperature peak lost");

    alert_follow_a: assert property (
        !soft_ff |=> alert_pin == ($past(cfg_ff[ESR_CFG_POL_BIT]) ~^ $past(alert_active)))
        else $error("alert pin does not follow flags");

endmodule

// *** logic/esr_pkg.sv ***
// constants and carrier types of the sensor register bank
// assumes a byte-level i2c target engine and a conversion engine on the same clock
package esr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ESR_OFF_TEMP_LO   = 8'h00;
    localparam logic [7:0] ESR_OFF_TEMP_HI   = 8'h01;
    localparam logic [7:0] ESR_OFF_HUM_LO    = 8'h02;
    localparam logic [7:0] ESR_OFF_HUM_HI    = 8'h03;
    localparam logic [7:0] ESR_OFF_FLAGS     = 8'h04;
    localparam logic [7:0] ESR_OFF_TEMP_PEAK = 8'h05;
    localparam logic [7:0] ESR_OFF_HUM_PEAK  = 8'h06;
    localparam logic [7:0] ESR_OFF_ENABLE    = 8'h07;
    localparam logic [7:0] ESR_OFF_TEMP_TRIM = 8'h08;
    localparam logic [7:0] ESR_OFF_HUM_TRIM  = 8'h09;
    localparam logic [7:0] ESR_OFF_TLIM_A    = 8'h0A;
    localparam logic [7:0] ESR_OFF_TLIM_B    = 8'h0B;
    localparam logic [7:0] ESR_OFF_HLIM_A    = 8'h0C;
    localparam logic [7:0] ESR_OFF_HLIM_B    = 8'h0D;
    localparam logic [7:0] ESR_OFF_CFG       = 8'h0E;
    localparam logic [7:0] ESR_OFF_MEAS      = 8'h0F;
    localparam logic [7:0] ESR_OFF_MAKER_LO  = 8'hFC;
    localparam logic [7:0] ESR_OFF_MAKER_HI  = 8'hFD;
    localparam logic [7:0] ESR_OFF_PART_LO   = 8'hFE;
    localparam logic [7:0] ESR_OFF_PART_HI   = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  ESR_RST_ZERO    = 8'h00;
    localparam logic [7:0]  ESR_RST_LIMIT_A = 8'hFF;
    localparam logic [15:0] ESR_RST_RESULT  = 16'h0000;
    localparam logic        ESR_RST_ALERT   = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int ESR_FLAG_DONE_BIT = 7;
    localparam int ESR_FLAG_THR_LSB  = 3;
    localparam int ESR_CFG_SOFT_BIT  = 7;
    localparam int ESR_CFG_EN_BIT    = 2;
    localparam int ESR_CFG_POL_BIT   = 1;
    localparam int ESR_CFG_LATCH_BIT = 0;
    localparam int ESR_MEAS_TRES_LSB = 6;
    localparam int ESR_MEAS_HRES_LSB = 4;

    // result word layout: 14 bits on top, two forced zeros below
    localparam logic [15:0] ESR_KEEP_14 = 16'hFFFC;
    localparam logic [15:0] ESR_KEEP_11 = 16'hFFE0;
    localparam logic [15:0] ESR_KEEP_9  = 16'hFF80;
    localparam logic [1:0]  ESR_RES_11  = 2'h1;
    localparam logic [1:0]  ESR_RES_9   = 2'h2;

    typedef enum logic [2:0] {
        ESR_KIND_PTR   = 3'b001,
        ESR_KIND_WRITE = 3'b010,
        ESR_KIND_READ  = 3'b100
    } esr_kind_e;

    typedef struct packed {
        logic       valid;
        esr_kind_e  kind;
        logic [7:0] data;
    } esr_req_s;

    typedef struct packed {
        logic       valid;
        logic       ack;
        logic [7:0] data;
    } esr_rsp_s;

    typedef struct packed {
        logic        done;
        logic [13:0] temp;
        logic [13:0] hum;
    } esr_conv_s;

endpackage

// *** verif/esr_bank_test.sv ***
// self-checking bench of the sensor register bank
// assumes esr_pkg compiled first; the host model issues every bus byte
module esr_bank_test;
    import esr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] IDS [4] = '{8'h6E, 8'h91, 8'h2B, 8'hD4}; // arbitrary identity values

    logic       clk;
    logic       reset_n;
    esr_req_s   req;
    esr_rsp_s   rsp;
    esr_conv_s  conv;
    logic       alert;
    int         err_count;
    int         n_compared;
    int         cycles;
    logic [9:0] exp_q [$];
    logic [9:0] e;
    logic [7:0] regs [16];
    logic [7:0] ptr;

    esr_bank #(.MAKER_LO(IDS[0]), .MAKER_HI(IDS[1]), .PART_LO(IDS[2]), .PART_HI(IDS[3]))
    esr_bank_inst (.clk(clk), .reset_n(reset_n), .bus_req(req), .bus_rsp(rsp),
                   .conv(conv), .alert_pin(alert));
    esr_host esr_host_inst (.clk(clk), .req(req));

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // reporting
    task automatic report_and_stop();
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic fail_at(input logic [15:0] got, input logic [15:0] want);
        err_count++;
        $display("mismatch at %0t: got %0h expected %0h", $time, got, want);
    endtask

    // hang guard; a full run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            err_count++;
            report_and_stop();
        end
    end

    // every response is matched against the oldest note
    always @(negedge clk) begin
        if (rsp.valid === 1'b1) begin
            n_compared++;
            if (exp_q.size() == 0) begin
                fail_at({7'h00, rsp.ack, rsp.data}, 16'h0000);
            end else begin
                e = exp_q.pop_front();
                if (rsp.ack !== e[8] || (e[9] && rsp.data !== e[7:0])) begin
                    fail_at({7'h00, rsp.ack, rsp.data}, {7'h00, e[8:0]});
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reference model of the register file
    task automatic model_reset();
        foreach (regs[i]) regs[i] = 8'h00;
        regs[10] = ESR_RST_LIMIT_A;
        regs[12] = ESR_RST_LIMIT_A;
        ptr = 8'h00;
    endtask

    function automatic logic [7:0] peek(input logic [7:0] a);
        if (a < 8'h10) return regs[a[3:0]];
        if (a > 8'hFB) return IDS[a[1:0]];
        return 8'h00;
    endfunction

    function automatic logic [15:0] adj(input logic [13:0] raw, input logic [7:0] trim,
                                        input logic [1:0] res);
        int          s;
        logic [15:0] keep;
        s = int'({raw, 2'b00}) + 64 * int'($signed(trim));
        if (s < 0) s = 0;
        if (s > 'hFFFC) s = 'hFFFC;
        keep = (res == ESR_RES_11) ? ESR_KEEP_11 : (res == ESR_RES_9) ? ESR_KEEP_9 : ESR_KEEP_14;
        return 16'(s) & keep;
    endfunction

    task automatic conv_model(input logic [13:0] t, input logic [13:0] h);
        logic [15:0] tw;
        logic [15:0] hw;
        logic [3:0]  nf;
        tw = adj(t, regs[8], regs[15][7:6]);
        hw = adj(h, regs[9], regs[15][5:4]);
        nf = {tw[15:8] > regs[10], tw[15:8] < regs[11], hw[15:8] > regs[12],
              hw[15:8] < regs[13]} & regs[7][6:3];
        regs[4][7] = 1'b1;
        regs[4][6:3] = regs[14][0] ? (regs[4][6:3] | nf) : nf;
        {regs[1], regs[0]} = tw;
        {regs[3], regs[2]} = hw;
        if (tw[15:8] > regs[5]) regs[5] = tw[15:8];
        if (hw[15:8] > regs[6]) regs[6] = hw[15:8];
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // bus and conversion drivers
    task automatic ptr_to(input logic [7:0] p);
        exp_q.push_back({1'b0, (p < 8'h10) || (p > 8'hFB), 8'h00});
        esr_host_inst.send(ESR_KIND_PTR, p);
        ptr = p;
    endtask

    task automatic wr(input logic [7:0] d);
        exp_q.push_back({1'b0, ptr < 8'hFC, 8'h00});
        esr_host_inst.send(ESR_KIND_WRITE, d);
        if (ptr > 8'h04 && ptr < 8'h10) begin
            regs[ptr[3:0]] = d & (ptr == 8'h07 ? 8'hF8 : ptr == 8'h0E ? 8'h7F : 8'hFF);
        end
        if (ptr == ESR_OFF_CFG && d[7]) model_reset();
        else ptr++;
    endtask

    task automatic rd();
        exp_q.push_back({1'b1, 1'b1, peek(ptr)});
        esr_host_inst.send(ESR_KIND_READ, 8'h00);
        if (ptr == ESR_OFF_FLAGS) regs[4] = 8'h00;
        if (ptr < 8'h04) regs[4][7] = 1'b0;
        ptr++;
    endtask

    // with_rd lands a read on the same edge as the conversion
    task automatic cvt(input logic [13:0] t, input logic [13:0] h, input logic with_rd);
        if (with_rd) rd();
        else @(negedge clk);
        conv <= '{done: 1'b1, temp: t, hum: h};
        conv_model(t, h);
        if (with_rd) esr_host_inst.idle();
        else @(negedge clk);
        conv.done <= 1'b0;
    endtask

    task automatic chk_alert();
        logic a;
        @(negedge clk);
        a = regs[14][2] & (|(regs[4][7:3] & regs[7][7:3]));
        a = regs[14][1] ? a : ~a;
        n_compared++;
        if (alert !== a) fail_at({15'h0000, alert}, {15'h0000, a});
    endtask

    task automatic dump();
        repeat (16) rd();
        esr_host_inst.idle();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        conv = '0;
        err_count = 0;
        n_compared = 0;
        cycles = 0;
        model_reset();
        void'($urandom(51));
        repeat (20) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        dump();
        ptr_to(ESR_OFF_MAKER_LO);
        repeat (5) rd();
        esr_host_inst.idle();
        chk_alert();
        ptr_to(8'h10);
        rd();
        ptr_to(8'(16 + $urandom % 236));
        ptr_to(ESR_OFF_PART_HI);
        wr(8'($urandom));
        ptr_to(ESR_OFF_PART_HI);
        rd();
        ptr_to(ESR_OFF_TEMP_LO);
        repeat (14) wr(8'($urandom));
        ptr_to(ESR_OFF_TEMP_LO);
        dump();
        for (int i = 0; i < 12; i++) begin
            ptr_to(ESR_OFF_ENABLE);
            wr(8'h80 | 8'($urandom));
            repeat (6) wr(8'($urandom));
            wr({6'b000001, i[1], i[0]});
            wr(8'($urandom) & 8'hF0);
            esr_host_inst.idle();
            cvt(14'($urandom), 14'($urandom), 1'b0);
            cvt(14'($urandom), 14'($urandom), 1'b0);
            chk_alert();
            if (i[0]) begin
                ptr_to(ESR_OFF_TEMP_LO);
                repeat (4) rd();
            end
            ptr_to(ESR_OFF_FLAGS);
            repeat (3) rd();
            ptr_to(ESR_OFF_TEMP_LO);
            repeat (5) rd();
            esr_host_inst.idle();
            chk_alert();
        end
        ptr_to(ESR_OFF_FLAGS);
        cvt(14'($urandom), 14'($urandom), 1'b1);
        ptr_to(ESR_OFF_FLAGS);
        rd();
        ptr_to(ESR_OFF_CFG);
        wr(8'h80);
        esr_host_inst.idle();
        repeat (3) @(negedge clk);
        dump();
        chk_alert();
        repeat (3) @(negedge clk);
        if (exp_q.size() != 0) fail_at(16'(exp_q.size()), 16'h0000);
        report_and_stop();
    end
endmodule

// *** verif/esr_host.sv ***
// host-side byte event source standing in for the i2c controller engine
// assumes one calling process and a free-running clk; changes req at the falling edge
module esr_host
    import esr_pkg::*;
(
    input  wire logic clk,
    output esr_req_s  req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    ////////////////////////////////////////////////////////////////////////////
    // one byte per call, held across exactly one rising edge
    task automatic send(input esr_kind_e kind, input logic [7:0] data);
        @(negedge clk);
        req <= '{valid: 1'b1, kind: kind, data: data};
    endtask

    // released data bits flip so a stale byte is never mistaken for a live one
    task automatic idle();
        @(negedge clk);
        req <= '{valid: 1'b0, kind: req.kind, data: ~req.data};
    endtask
endmodule
